/* File: verilog/acmd_pkg.sv */
// Constants, encodings and state types of the command acceptor.
// Assumes a 250 MHz system clock and an AHB-Lite register port.
//
// Notes on behaviour
// - Class 1: busy raised within 400 ns of the command write.
// - Class 2: busy within 400 ns, request within 700 us, busy drops after.
// - Class 3: busy within 400 ns, request within 20 ms, busy drops after.
// - Codes C5, CD and 3C decode as class 3 with full parameters.
// - Codes 30, 31, 38, CA, E8 and 50 decode as class 2.
// - F8 is class 1 drive-only; F9 is class 1 with full parameters.
// - Legacy codes 00 and 1x complete with no effect.
// - Power query in standby or transition loads count with 00.
// - Power query while idle loads count with FF.
// - Power query answers to 98 or E5 and uses only drive select.
// - Sector erase moves no data but may end with write fault.
// - Erase start comes from address fields, length from the count.
// - Drive-only commands drop head bits; full commands keep them.
// - Reads, verify, seek, erase and writes accept logical addressing.
// - EF uses features; B0 uses features, count, cylinder, drive select.
// - Drive/head bit 6 selects logical addressing, bit 4 the drive.
// - A zero count means 256 sectors.
// - While busy, other status bits read invalid; task file writes ignored.
`default_nettype none
package acmd_pkg;
	// ----------------------------------------------------------------
	// Register word offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FEATURE  = 8'h00;
	localparam logic [7:0] OFS_COUNT    = 8'h04;
	localparam logic [7:0] OFS_SECTOR   = 8'h08;
	localparam logic [7:0] OFS_CYL_LO   = 8'h0c;
	localparam logic [7:0] OFS_CYL_HI   = 8'h10;
	localparam logic [7:0] OFS_DRV_HEAD = 8'h14;
	localparam logic [7:0] OFS_CMD_STAT = 8'h18;
	localparam logic [7:0] OFS_DEV_CTRL = 8'h1c;
	localparam logic [7:0] OFS_ERROR    = 8'h20;
	localparam logic [7:0] OFS_DECODE   = 8'h24;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         DH_LBA_BIT   = 6;
	localparam int         DH_DRV_BIT   = 4;
	localparam int         CTRL_SRST    = 2;
	localparam int         ERR_ABRT     = 2;
	localparam logic [7:0] COUNT_RST    = 8'h01;
	localparam logic [7:0] DH_RST       = 8'ha0;
	localparam logic [7:0] STAT_BUSY    = 8'h80;
	localparam logic [7:0] PWR_STANDBY  = 8'h00;
	localparam logic [7:0] PWR_IDLE     = 8'hff;
	localparam logic [8:0] COUNT_MAX    = 9'h100;

	// Field-use mask bits
	localparam int U_FR  = 0;
	localparam int U_SC  = 1;
	localparam int U_SN  = 2;
	localparam int U_CY  = 3;
	localparam int U_DHF = 4;
	localparam int U_LBA = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int BSY_MAX_NS   = 400;
	localparam int DRQ_C2_US    = 700;
	localparam int DRQ_C3_MS    = 20;
	localparam int BSY_MAX_CYC  = (BSY_MAX_NS * CLK_MHZ) / 1000;
	localparam int DRQ_C2_CYC   = DRQ_C2_US * CLK_MHZ;
	localparam int DRQ_C3_CYC   = DRQ_C3_MS * CLK_MHZ * 1000;
	localparam int TMR_W        = 24;

	typedef enum logic [1:0] {K_NOP, K_POWER, K_EXEC, K_XFER} acmd_kind_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ACCEPT, ST_EXEC, ST_PREP, ST_DRQ_ON,
		ST_XFER} acmd_st_t;
endpackage
`default_nettype wire

/* File: verilog/acmd_decoder.sv */
// Command code decoder: class, handling kind and task-file field use.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/1ps
`default_nettype none
module acmd_decoder (
	input  wire logic [7:0]          i_code,
	output logic                     o_valid,
	output logic [1:0]               o_cls,
	output acmd_pkg::acmd_kind_t     o_kind,
	output logic [5:0]               o_use,
	output logic                     o_erase
);
	localparam logic [5:0] M_D    = 6'h00;
	localparam logic [5:0] M_FULL = 6'h3e;

	always_comb begin
		o_valid = 1'b1;
		o_cls   = 2'd1;
		o_kind  = acmd_pkg::K_EXEC;
		o_use   = M_D;
		o_erase = 1'b0;
		casez (i_code)
			8'h00, 8'h1?: o_kind = acmd_pkg::K_NOP;
			8'h98, 8'he5: o_kind = acmd_pkg::K_POWER;
			8'hc0: begin
				o_use   = M_FULL;
				o_erase = 1'b1;
			end
			8'h20, 8'h21, 8'h40, 8'h41, 8'hc4, 8'hc8, 8'h87, 8'hf9:
				o_use = M_FULL;
			8'h7?: o_use = M_FULL & ~(6'h1 << acmd_pkg::U_SC);
			8'h90, 8'he7, 8'hec, 8'he4, 8'he1, 8'h95, 8'he6, 8'h99, 8'he2,
			8'h96, 8'he0, 8'h94, 8'h03, 8'hf8: o_use = M_D;
			8'he3, 8'h97, 8'hc6: o_use = 6'h1 << acmd_pkg::U_SC;
			8'h91: o_use = (6'h1 << acmd_pkg::U_SC) | (6'h1 << acmd_pkg::U_DHF);
			8'hf5: o_use = 6'h1 << acmd_pkg::U_DHF;
			8'hef: o_use = 6'h1 << acmd_pkg::U_FR;
			8'hb0: o_use = (6'h1 << acmd_pkg::U_FR) | (6'h1 << acmd_pkg::U_SC)
				| (6'h1 << acmd_pkg::U_CY);
			8'h30, 8'h31, 8'h38, 8'hca: begin
				o_cls  = 2'd2;
				o_kind = acmd_pkg::K_XFER;
				o_use  = M_FULL;
			end
			8'he8: begin
				o_cls  = 2'd2;
				o_kind = acmd_pkg::K_XFER;
			end
			8'h50: begin
				o_cls  = 2'd2;
				o_kind = acmd_pkg::K_XFER;
				o_use  = M_FULL & ~(6'h1 << acmd_pkg::U_SN);
			end
			8'hc5, 8'hcd, 8'h3c: begin
				o_cls  = 2'd3;
				o_kind = acmd_pkg::K_XFER;
				o_use  = M_FULL;
			end
			default: begin
				o_valid = 1'b0;
				o_cls   = 2'd0;
				o_kind  = acmd_pkg::K_NOP;
			end
		endcase
	end
endmodule // acmd_decoder
`default_nettype wire

/* File: verilog/acmd_deadline.sv */
// Down counter that flags when a loaded deadline runs out.
// Counts only while run is high; load restarts it.
`timescale 1ns/1ps
`default_nettype none
module acmd_deadline #(
	parameter int W = 24
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rstn,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_limit,
	input  wire logic         i_run,
	output logic              o_expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         exp;
	} acmd_tmr_t;

	if (W < 1) begin : g_bad_width
		$error("acmd_deadline: counter width must be at least one");
	end

	acmd_tmr_t q, d;

	always_comb begin
		d = q;
		if (i_load) begin
			d.cnt = i_limit;
			d.exp = 1'b0;
		end else if (i_run) begin
			if (q.cnt == '0)
				d.exp = 1'b1;
			else
				d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn)
			q <= '0;
		else
			q <= d;
	end

	assign o_expired = q.exp;
endmodule // acmd_deadline
`default_nettype wire

/* File: verilog/acmd_top.sv */
// Task-file command acceptor: AHB-Lite registers, decode, busy/request timing.
// Assumes a media back end that answers start with done, buffer ready or end.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acmd_top #(
	parameter int P_DRQ2_CYC = acmd_pkg::DRQ_C2_CYC,
	parameter int P_DRQ3_CYC = acmd_pkg::DRQ_C3_CYC
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_standby,
	input  wire logic        i_exec_done,
	input  wire logic        i_exec_fault,
	input  wire logic        i_buf_ready,
	input  wire logic        i_xfer_done,
	output logic             o_bsy,
	output logic             o_drq,
	output logic             o_cmd_start,
	output logic [7:0]       o_cmd_code,
	output logic [1:0]       o_cmd_class,
	output logic             o_cmd_erase,
	output logic [27:0]      o_start_addr,
	output logic [8:0]       o_sector_count,
	output logic [7:0]       o_feature,
	output logic             o_lba_mode,
	output logic             o_drive_sel,
	output logic             o_cmd_done
);
	localparam int TW = acmd_pkg::TMR_W;

	if (P_DRQ2_CYC < 1 || P_DRQ3_CYC < 1
		|| P_DRQ2_CYC >= 2**TW || P_DRQ3_CYC >= 2**TW) begin : g_bad_deadline
		$error("acmd_top: deadline counts out of range");
	end

	typedef struct packed {
		acmd_pkg::acmd_st_t st;
		logic [7:0]  feat;
		logic [7:0]  cnt;
		logic [7:0]  sec;
		logic [7:0]  cyl_lo;
		logic [7:0]  cyl_hi;
		logic [7:0]  dh;
		logic [7:0]  cmd;
		logic        srst;
		logic        bsy;
		logic        drq;
		logic        err;
		logic        write_fault_flag;
		logic        abrt;
		logic        dph;
		logic        dwr;
		logic [7:0]  daddr;
		logic        ready;
		logic [31:0] rdata;
		logic        start;
		logic        done;
		logic [1:0]  cls;
		logic        erase;
		logic [27:0] addr;
		logic [8:0]  scount;
		logic [7:0]  ofeat;
		logic        lba;
		logic        drv;
	} acmd_state_t;

	acmd_state_t q, d;

	logic                 dec_valid;
	logic [1:0]           dec_cls;
	acmd_pkg::acmd_kind_t dec_kind;
	logic [5:0]           dec_use;
	logic                 dec_erase;
	logic                 tmr_load;
	logic [TW-1:0]        tmr_limit;
	logic                 tmr_exp;

	acmd_decoder u_dec (
		.i_code  (q.cmd),
		.o_valid (dec_valid),
		.o_cls   (dec_cls),
		.o_kind  (dec_kind),
		.o_use   (dec_use),
		.o_erase (dec_erase)
	);

	// Buffer preparation deadline for class 2 and 3
	assign tmr_load  = (q.st == acmd_pkg::ST_ACCEPT) && dec_valid
		&& (dec_kind == acmd_pkg::K_XFER);
	assign tmr_limit = (dec_cls == 2'd3) ? TW'(P_DRQ3_CYC) : TW'(P_DRQ2_CYC);

	acmd_deadline #(.W(TW)) u_tmr (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_load    (tmr_load),
		.i_limit   (tmr_limit),
		.i_run     (q.st == acmd_pkg::ST_PREP),
		.o_expired (tmr_exp)
	);

	logic [7:0] stat_val;
	logic [7:0] rd_val;

	always_comb begin
		// Busy masks the other bits, they mean nothing then
		if (q.bsy || q.srst)
			stat_val = acmd_pkg::STAT_BUSY;
		else
			stat_val = {1'b0, 1'b1, q.write_fault_flag, 1'b1, q.drq, 2'b00, q.err};
		case (q.daddr)
			acmd_pkg::OFS_FEATURE:  rd_val = q.feat;
			acmd_pkg::OFS_COUNT:    rd_val = q.cnt;
			acmd_pkg::OFS_SECTOR:   rd_val = q.sec;
			acmd_pkg::OFS_CYL_LO:   rd_val = q.cyl_lo;
			acmd_pkg::OFS_CYL_HI:   rd_val = q.cyl_hi;
			acmd_pkg::OFS_DRV_HEAD: rd_val = q.dh;
			acmd_pkg::OFS_CMD_STAT: rd_val = stat_val;
			acmd_pkg::OFS_ERROR:    rd_val = 8'({7'h00, q.abrt} << acmd_pkg::ERR_ABRT);
			acmd_pkg::OFS_DECODE:   rd_val = {1'b0, q.erase, q.lba, q.drv, q.cls, q.drq, q.bsy};
			default:                rd_val = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d       = q;
		d.start = 1'b0;
		d.done  = 1'b0;

		// Read data phase: one wait state so a preceding write is visible
		if (q.dph && !q.dwr && !q.ready) begin
			d.rdata = {24'h000000, rd_val};
			d.ready = 1'b1;
		end
		if (q.dph && q.dwr) begin
			if (q.daddr == acmd_pkg::OFS_DEV_CTRL)
				d.srst = i_hwdata[acmd_pkg::CTRL_SRST];
			else if (!q.bsy && !q.srst) begin
				case (q.daddr)
					acmd_pkg::OFS_FEATURE:  d.feat   = i_hwdata[7:0];
					acmd_pkg::OFS_COUNT:    d.cnt    = i_hwdata[7:0];
					acmd_pkg::OFS_SECTOR:   d.sec    = i_hwdata[7:0];
					acmd_pkg::OFS_CYL_LO:   d.cyl_lo = i_hwdata[7:0];
					acmd_pkg::OFS_CYL_HI:   d.cyl_hi = i_hwdata[7:0];
					acmd_pkg::OFS_DRV_HEAD: d.dh     = i_hwdata[7:0];
					acmd_pkg::OFS_CMD_STAT: begin
						d.cmd  = i_hwdata[7:0];
						d.bsy  = 1'b1;
						d.drq  = 1'b0;
						d.err  = 1'b0;
						d.write_fault_flag  = 1'b0;
						d.abrt = 1'b0;
						d.st   = acmd_pkg::ST_ACCEPT;
					end
					default: ;
				endcase
			end
		end
		if (i_hready) begin
			d.dph   = i_hsel && i_htrans[1];
			d.dwr   = i_hwrite;
			d.daddr = i_haddr[7:0];
			d.ready = !(i_hsel && i_htrans[1] && !i_hwrite);
		end

		case (q.st)
			acmd_pkg::ST_IDLE: ;
			acmd_pkg::ST_ACCEPT: begin
				d.st    = acmd_pkg::ST_IDLE;
				d.cls   = dec_cls;
				d.erase = dec_erase;
				d.lba   = dec_use[acmd_pkg::U_LBA] && q.dh[acmd_pkg::DH_LBA_BIT];
				d.drv   = q.dh[acmd_pkg::DH_DRV_BIT];
				d.ofeat = dec_use[acmd_pkg::U_FR] ? q.feat : 8'h00;
				d.addr  = {dec_use[acmd_pkg::U_DHF] ? q.dh[3:0] : 4'h0,
					dec_use[acmd_pkg::U_CY] ? {q.cyl_hi, q.cyl_lo} : 16'h0000,
					dec_use[acmd_pkg::U_SN] ? q.sec : 8'h00};
				if (!dec_use[acmd_pkg::U_SC])
					d.scount = 9'h000;
				else if (q.cnt == 8'h00)
					d.scount = acmd_pkg::COUNT_MAX;
				else
					d.scount = {1'b0, q.cnt};
				if (!dec_valid) begin
					d.err  = 1'b1;
					d.abrt = 1'b1;
					d.bsy  = 1'b0;
					d.done = 1'b1;
					d.cls  = q.cls;
					d.erase= q.erase;
					d.lba  = q.lba;
					d.drv  = q.drv;
					d.ofeat= q.ofeat;
					d.addr = q.addr;
					d.scount = q.scount;
				end else begin
					case (dec_kind)
						acmd_pkg::K_NOP: begin
							d.bsy  = 1'b0;
							d.done = 1'b1;
						end
						acmd_pkg::K_POWER: begin
							d.cnt  = i_standby ? acmd_pkg::PWR_STANDBY
								: acmd_pkg::PWR_IDLE;
							d.bsy  = 1'b0;
							d.done = 1'b1;
						end
						acmd_pkg::K_EXEC: begin
							d.start = 1'b1;
							d.st    = acmd_pkg::ST_EXEC;
						end
						default: begin
							d.start = 1'b1;
							d.st    = acmd_pkg::ST_PREP;
						end
					endcase
				end
			end
			acmd_pkg::ST_EXEC: if (i_exec_done) begin
				d.bsy  = 1'b0;
				d.err  = i_exec_fault;
				d.write_fault_flag  = i_exec_fault && q.erase;
				d.done = 1'b1;
				d.st   = acmd_pkg::ST_IDLE;
			end
			acmd_pkg::ST_PREP: begin
				if (i_buf_ready) begin
					d.drq = 1'b1;
					d.st  = acmd_pkg::ST_DRQ_ON;
				end else if (tmr_exp) begin
					// Buffer never came: give up rather than hang busy
					d.bsy  = 1'b0;
					d.err  = 1'b1;
					d.write_fault_flag  = 1'b1;
					d.done = 1'b1;
					d.st   = acmd_pkg::ST_IDLE;
				end
			end
			acmd_pkg::ST_DRQ_ON: begin
				d.bsy = 1'b0;
				d.st  = acmd_pkg::ST_XFER;
			end
			acmd_pkg::ST_XFER: if (i_xfer_done) begin
				d.drq  = 1'b0;
				d.err  = i_exec_fault;
				d.write_fault_flag  = i_exec_fault;
				d.done = 1'b1;
				d.st   = acmd_pkg::ST_IDLE;
			end
			default: d.st = acmd_pkg::ST_IDLE;
		endcase

		// Soft reset holds the task file and sequencer cleared
		if (q.srst) begin
			d.st     = acmd_pkg::ST_IDLE;
			d.bsy    = 1'b0;
			d.drq    = 1'b0;
			d.err    = 1'b0;
			d.write_fault_flag    = 1'b0;
			d.abrt   = 1'b0;
			d.start  = 1'b0;
			d.done   = 1'b0;
			d.feat   = 8'h00;
			d.cnt    = acmd_pkg::COUNT_RST;
			d.sec    = 8'h00;
			d.cyl_lo = 8'h00;
			d.cyl_hi = 8'h00;
			d.dh     = acmd_pkg::DH_RST;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			q       <= '0;
			q.cnt   <= acmd_pkg::COUNT_RST;
			q.dh    <= acmd_pkg::DH_RST;
			q.ready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_hrdata       = q.rdata;
	assign o_hreadyout    = q.ready;
	assign o_hresp        = q.abrt & 1'b0;
	assign o_bsy          = q.bsy;
	assign o_drq          = q.drq;
	assign o_cmd_start    = q.start;
	assign o_cmd_code     = q.cmd;
	assign o_cmd_class    = q.cls;
	assign o_cmd_erase    = q.erase;
	assign o_start_addr   = q.addr;
	assign o_sector_count = q.scount;
	assign o_feature      = q.ofeat;
	assign o_lba_mode     = q.lba;
	assign o_drive_sel    = q.drv;
	assign o_cmd_done     = q.done;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int LP_BSY_CYC = acmd_pkg::BSY_MAX_CYC;
	logic cmd_wr;
	assign cmd_wr = q.dph && q.dwr && (q.daddr == acmd_pkg::OFS_CMD_STAT) && !q.bsy && !q.srst;

	a_bsy_on_cmd: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		cmd_wr |=> q.bsy || q.srst)
		else $error("busy not raised after command write");
	a_bsy_after_drq: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		$rose(q.drq) |-> ##[1:LP_BSY_CYC] !q.bsy)
		else $error("busy still set after data request");
	a_class3_dec: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && (q.cmd == 8'hc5 || q.cmd == 8'h3c))
		|=> q.cls == 2'd3 && q.st == acmd_pkg::ST_PREP && q.start)
		else $error("class 3 code misdecoded");
	a_class2_dec: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && q.cmd == 8'h30 && !q.srst) |=> q.cls == 2'd2)
		else $error("class 2 code misdecoded");
	a_power_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && q.cmd == 8'he5 && !i_standby && !q.srst)
		|=> q.cnt == acmd_pkg::PWR_IDLE && !q.bsy && q.done)
		else $error("idle power query answer wrong");
	a_unknown_abort: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && !dec_valid && !q.srst)
		|=> q.err && q.abrt && !q.bsy && $stable(q.cnt) && $stable(q.addr))
		else $error("unknown code not aborted");
	a_busy_locks: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.bsy && !q.srst && q.dph && q.dwr && q.daddr == acmd_pkg::OFS_SECTOR)
		|=> $stable(q.sec))
		else $error("task file written while busy");
	a_count_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && q.cmd == 8'h20 && q.cnt == 8'h00 && !q.srst)
		|=> o_sector_count == acmd_pkg::COUNT_MAX)
		else $error("zero count not 256");
	a_drive_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(q.st == acmd_pkg::ST_ACCEPT && q.cmd == 8'hf8 && !q.srst) |=> q.addr[27:24] == 4'h0)
		else $error("head bits kept for drive-only command");
endmodule // acmd_top
`default_nettype wire

/* File: tb/acmd_backend_model.sv */
// Behavioural media back end facing the command acceptor.
// Assumes start, class and request come straight from acmd_top.
`timescale 1ns/1ps
`default_nettype none
module acmd_backend_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_cmd_start,
	input  wire logic [1:0] i_cmd_class,
	input  wire logic       i_drq,
	input  wire logic [7:0] i_delay,
	input  wire logic       i_fault,
	input  wire logic       i_stall,
	output logic            o_exec_done,
	output logic            o_exec_fault,
	output logic            o_buf_ready,
	output logic            o_xfer_done
);
	int n;
	initial begin
		o_exec_done = 1'b0;
		o_exec_fault = 1'b1;
		o_buf_ready = 1'b0;
		o_xfer_done = 1'b0;
		forever begin
			@(posedge i_clk_sys);
			if (i_cmd_start === 1'b1) begin
				repeat (i_delay) @(posedge i_clk_sys);
				if (i_cmd_class == 2'd1) begin
					o_exec_fault <= i_fault;
					o_exec_done <= 1'b1;
					@(posedge i_clk_sys);
					o_exec_done <= 1'b0;
					// Fault is only meaningful beside done
					o_exec_fault <= ~i_fault;
				end else if (i_stall == 1'b0) begin
					o_buf_ready <= 1'b1;
					n = 0;
					while (i_drq !== 1'b1 && n < 64) begin
						@(posedge i_clk_sys);
						n++;
					end
					o_buf_ready <= 1'b0;
					repeat (i_delay) @(posedge i_clk_sys);
					o_exec_fault <= i_fault;
					o_xfer_done <= 1'b1;
					@(posedge i_clk_sys);
					o_xfer_done <= 1'b0;
					o_exec_fault <= ~i_fault;
				end
			end
		end
	end
endmodule // acmd_backend_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench: AHB-Lite master tasks and command sequences.
// Assumes acmd_top with short request deadlines and the back end model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_sys, rstn, hsel, hwrite, hreadyout, hresp, standby;
	logic        exec_done, exec_fault, buf_ready, xfer_done, bsy, drq;
	logic        cmd_start, cmd_erase, lba_mode, drive_sel, cmd_done, fault, stall, drq_last;
	logic [31:0] haddr, hwdata, hrdata;
	logic [27:0] start_addr;
	logic [8:0]  sector_count;
	logic [7:0]  cmd_code, feature, delay, code;
	logic [1:0]  htrans, cmd_class;
	int          error_cnt, num_checks, start_cnt, drq_bsy_n, drq_cnt, k;

	acmd_top #(.P_DRQ2_CYC(20), .P_DRQ3_CYC(40)) i_acmd_top (
		.i_clk_sys(clk_sys), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
		.o_hresp(hresp), .i_standby(standby), .i_exec_done(exec_done),
		.i_exec_fault(exec_fault), .i_buf_ready(buf_ready), .i_xfer_done(xfer_done),
		.o_bsy(bsy), .o_drq(drq), .o_cmd_start(cmd_start), .o_cmd_code(cmd_code),
		.o_cmd_class(cmd_class), .o_cmd_erase(cmd_erase), .o_start_addr(start_addr),
		.o_sector_count(sector_count), .o_feature(feature), .o_lba_mode(lba_mode),
		.o_drive_sel(drive_sel), .o_cmd_done(cmd_done));

	acmd_backend_model i_acmd_backend_model (
		.i_clk_sys(clk_sys), .i_cmd_start(cmd_start), .i_cmd_class(cmd_class),
		.i_drq(drq), .i_delay(delay), .i_fault(fault), .i_stall(stall),
		.o_exec_done(exec_done), .o_exec_fault(exec_fault),
		.o_buf_ready(buf_ready), .o_xfer_done(xfer_done));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task bad(input string m);
		error_cnt++;
		$display("BAD %0t %s", $time, m);
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) bad($sformatf("got %h expected %h", got, exp));
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Samples ready at each rising edge, bounded
	task hwait;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 32);
		if (hreadyout !== 1'b1) begin
			bad("bus hang");
			report_and_stop;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		hsel <= 1'b1;
		hwait;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		hwait;
	endtask

	task rd_cmp(input logic [7:0] a, input logic [7:0] exp);
		haddr <= {24'h000000, a};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		hsel <= 1'b1;
		hwait;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwait;
		cmp(hrdata, {24'h000000, exp});
	endtask

	// Feature, count, sector, cylinder low/high, drive/head in that order
	task load(input logic [47:0] v);
		for (int j = 0; j < 6; j++) wr(8'(j * 4), {24'h000000, v[47-8*j -: 8]});
	endtask

	task finish(input logic [7:0] st);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_done !== 1'b1 && n < 200);
		if (cmd_done !== 1'b1) begin
			bad("command hang");
			report_and_stop;
		end
		rd_cmp(8'h18, st);
	endtask

	task run(input logic [7:0] c, input logic [7:0] st);
		wr(8'h18, {24'h000000, c});
		@(posedge clk_sys);
		cmp(bsy, 1'b1);
		finish(st);
	endtask

	always @(posedge clk_sys) begin
		if (cmd_start === 1'b1) start_cnt <= start_cnt + 1;
		drq_last <= drq;
		if (drq === 1'b1 && drq_last !== 1'b1) drq_cnt <= drq_cnt + 1;
		drq_bsy_n <= (drq === 1'b1 && bsy === 1'b1) ? drq_bsy_n + 1 : 0;
		if (drq_bsy_n > 100) bad("busy held after request");
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rstn, hsel, hwrite, standby, fault, stall} = '0;
		{haddr, hwdata, htrans} = '0;
		delay = 8'h03;
		{error_cnt, num_checks, start_cnt, drq_bsy_n, drq_cnt} = '0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_cmp(8'h04, 8'h01);
		rd_cmp(8'h14, 8'ha0);
		rd_cmp(8'h18, 8'h50);
		rd_cmp(8'h40, 8'h00);
		wr(8'h04, 32'h00000012);
		wr(8'h1c, 32'h00000004);
		rd_cmp(8'h18, 8'h80);
		rd_cmp(8'h04, 8'h01);
		wr(8'h1c, 32'h00000000);
		$display("end of reset test");
		for (k = 0; k < 4; k++) begin
			standby <= k[1];
			wr(8'h04, 32'h00000012);
			run(k[0] ? 8'h98 : 8'he5, 8'h50);
			rd_cmp(8'h04, k[1] ? 8'h00 : 8'hff);
		end
		$display("end of power query test");
		k = start_cnt;
		wr(8'h04, 32'h00000012);
		run(8'h00, 8'h50);
		run(8'h17, 8'h50);
		cmp(start_cnt, k);
		run(8'hff, 8'h51);
		rd_cmp(8'h20, 8'h04);
		cmp(hresp, 1'b0);
		rd_cmp(8'h04, 8'h12);
		$display("end of no-effect test");
		load(48'h00_05_11_22_33_e5);
		for (k = 0; k < 12; k++) begin
			code = 8'(96'hc5_cd_3c_30_31_38_ca_e8_50_f8_f9_c0 >> (88 - 8 * k));
			run(code, 8'h50);
			cmp(cmd_code, code);
			cmp(cmd_class, (k < 3) ? 2'd3 : (k < 9) ? 2'd2 : 2'd1);
			cmp(cmd_erase, k == 11);
		end
		cmp(drq_cnt, 9);
		$display("end of class test");
		fault <= 1'b1;
		load(48'h00_05_11_22_33_a3);
		run(8'hc0, 8'h71);
		cmp(start_addr, 28'h3332211);
		cmp(sector_count, 9'h005);
		cmp(lba_mode, 1'b0);
		fault <= 1'b0;
		load(48'h00_00_11_22_33_ff);
		run(8'hf8, 8'h50);
		cmp(start_addr, 28'h0000000);
		cmp(drive_sel, 1'b1);
		run(8'hf9, 8'h50);
		cmp(start_addr, 28'hf332211);
		cmp(sector_count, 9'h100);
		cmp(lba_mode, 1'b1);
		run(8'h20, 8'h50);
		cmp(sector_count, 9'h100);
		cmp(lba_mode, 1'b1);
		$display("end of field use test");
		load(48'h3c_00_11_22_33_e5);
		delay <= 8'd30;
		wr(8'h18, 32'h000000c5);
		rd_cmp(8'h18, 8'h80);
		wr(8'h00, 32'h00000099);
		wr(8'h08, 32'h00000077);
		finish(8'h50);
		rd_cmp(8'h08, 8'h11);
		delay <= 8'h03;
		run(8'hef, 8'h50);
		cmp(feature, 8'h3c);
		stall <= 1'b1;
		run(8'h30, 8'h71);
		stall <= 1'b0;
		$display("end of busy and deadline test");
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
